// ==== core/pmlc_consts.vh ====
// constants for the power mode and laser control block
// Functional notes
// R1 - active to rest1 after idle x8 frames
// R2 - active from system clock, rest from hibernate
// R3 - rest1 frame every (code+1) x 10ms
// R4 - rest1 to rest2 after idle x16 frames
// R5 - rest2 frame every (code+1) x 10ms
// R6 - rest2 to rest3 after idle x128 frames
// R7 - rest3 frame every (code+1) x 10ms
// R8 - span bits must complement pair register
// R9 - pair check uses current contents, any order
// R10 - span 10 invalid, laser off
// R11 - calibration 101 continuous on, 000 exits
// R12 - motion read clears calibration bits
// R13 - kill bit holds laser pin high
// R14 - current code must complement pair register
// R15 - eight-bit current code drives dac
// R16 - stay-active bit blocks stepping down
// R17 - power state reported as two bits
// R18 - motion returns active, restarts idle
// R19 - rest3 holds until motion or stay-active
`ifndef PMLC_CONSTS_VH
`define PMLC_CONSTS_VH
// register addresses (7-bit)
`define PMLC_A_MOTION     7'h02
`define PMLC_A_MOTION_ALT 7'h42
`define PMLC_A_CONFIG     7'h12
`define PMLC_A_RUN_IDLE   7'h13
`define PMLC_A_R1_PER     7'h14
`define PMLC_A_R1_IDLE    7'h15
`define PMLC_A_R2_PER     7'h16
`define PMLC_A_R2_IDLE    7'h17
`define PMLC_A_R3_PER     7'h18
`define PMLC_A_LCTRL      7'h1a
`define PMLC_A_LCUR       7'h1c
`define PMLC_A_LCUR_INV   7'h1d
`define PMLC_A_LCTRL_INV  7'h1f
`define PMLC_A_OBS        7'h2e
// reset values
`define PMLC_RV_CONFIG    8'h26
`define PMLC_RV_RUN_IDLE  8'h04
`define PMLC_RV_R1_PER    8'h01
`define PMLC_RV_R1_IDLE   8'h1f
`define PMLC_RV_R2_PER    8'h09
`define PMLC_RV_R2_IDLE   8'h2f
`define PMLC_RV_R3_PER    8'h31
`define PMLC_RV_ZERO      8'h00
// field positions
`define PMLC_B_AWAKE      3
`define PMLC_B_KILL       0
`define PMLC_B_SPAN_HI    7
`define PMLC_B_SPAN_LO    5
`define PMLC_B_MOT        7
`define PMLC_B_LSOK       5
`define PMLC_F_RATE       2:0
`define PMLC_F_CAL        3:1
// field values
`define PMLC_CAL_CW       3'h5
`define PMLC_CAL_OFF      3'h0
`define PMLC_SPAN_BAD     2'h2
`define PMLC_RUN_RATE_OFS 4'h2
`define PMLC_CMD_WR_BIT   7
// timing, in ns
`define PMLC_CLK_NS       5
`define PMLC_ACT_BASE_NS  1000000
`define PMLC_HIB_BASE_NS  10000000
`endif

// ==== core/pmlc_tick.v ====
// free-running divider giving a one-cycle tick every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module pmlc_tick #(
   parameter integer DIV = 200000,
   parameter integer W   = 32
) (
   input  wire         clk,
   input  wire         rst,
   input  wire         restart,
   output reg          tick_ff
);
   reg  [W-1:0] cnt_ff;   // cycles since last tick
   wire         wrap;     // last cycle of a period
   assign wrap = (cnt_ff == DIV[W-1:0] - {{(W-1){1'b0}}, 1'b1});
   // restart realigns the base so a new state starts a full period
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff  <= {W{1'b0}};
         tick_ff <= 1'b0;
      end else if (restart) begin
         cnt_ff  <= {W{1'b0}};
         tick_ff <= 1'b0;
      end else begin
         cnt_ff  <= wrap ? {W{1'b0}} : cnt_ff + {{(W-1){1'b0}}, 1'b1};
         tick_ff <= wrap;
      end
   end
endmodule
`default_nettype wire

// ==== core/pmlc_serial.v ====
// four-wire serial register port, mode 3, msb first
`timescale 1ns/1ps
`default_nettype none
`include "pmlc_consts.vh"
module pmlc_serial (
   input  wire         clk,
   input  wire         rst,
   input  wire         sclk,
   input  wire         mosi,
   input  wire         ncs_n,
   input  wire [7:0]   rdata,
   output reg  [6:0]   addr_ff,
   output reg  [7:0]   wdata_ff,
   output reg          wr_ff,
   output reg          rd_ff,
   output reg          miso_ff,
   output reg          miso_oe_ff
);
   reg        sclk_d_ff;  // previous sclk for edge detect
   reg  [3:0] bit_ff;     // bits received in this frame
   reg  [7:0] sh_ff;      // input shift register
   reg  [7:0] out_ff;     // output shift register
   reg        is_wr_ff;   // first byte marked a write
   wire       rise;
   wire       fall;
   wire [7:0] nxt_sh;
   assign rise   = sclk & ~sclk_d_ff;
   assign fall   = ~sclk & sclk_d_ff;
   assign nxt_sh = {sh_ff[6:0], mosi};
   // pins are taken as synchronous, so edges come from one delay stage
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_d_ff  <= 1'b1;
         bit_ff     <= 4'h0;
         sh_ff      <= 8'h00;
         out_ff     <= 8'h00;
         is_wr_ff   <= 1'b0;
         addr_ff    <= 7'h00;
         wdata_ff   <= 8'h00;
         wr_ff      <= 1'b0;
         rd_ff      <= 1'b0;
         miso_ff    <= 1'b0;
         miso_oe_ff <= 1'b0;
      end else begin
         sclk_d_ff <= sclk;
         wr_ff     <= 1'b0;
         rd_ff     <= 1'b0;
         if (ncs_n) begin
            // deselect aborts any partial byte
            bit_ff     <= 4'h0;
            miso_oe_ff <= 1'b0;
         end else if (rise) begin
            sh_ff  <= nxt_sh;
            bit_ff <= (bit_ff == 4'hf) ? 4'h0 : bit_ff + 4'h1;
            if (bit_ff == 4'h7) begin
               // address byte complete
               addr_ff  <= nxt_sh[6:0];
               is_wr_ff <= nxt_sh[`PMLC_CMD_WR_BIT];
               rd_ff    <= ~nxt_sh[`PMLC_CMD_WR_BIT];
            end else if (bit_ff == 4'hf && is_wr_ff) begin
               wdata_ff <= nxt_sh;
               wr_ff    <= 1'b1;
            end
         end else if (fall) begin
            // read data leaves on falling edges after the address
            if (bit_ff == 4'h8 && !is_wr_ff) begin
               miso_ff    <= rdata[7];
               out_ff     <= {rdata[6:0], 1'b0};
               miso_oe_ff <= 1'b1;
            end else if (bit_ff > 4'h8 && !is_wr_ff) begin
               miso_ff <= out_ff[7];
               out_ff  <= {out_ff[6:0], 1'b0};
            end else if (bit_ff == 4'h0) begin
               miso_oe_ff <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== core/pmlc_top.v ====
// power state sequencer and laser drive control with its register port
`timescale 1ns/1ps
`default_nettype none
`include "pmlc_consts.vh"
module pmlc_top #(
   parameter integer ACT_BASE_CYC = `PMLC_ACT_BASE_NS / `PMLC_CLK_NS,
   parameter integer HIB_BASE_CYC = `PMLC_HIB_BASE_NS / `PMLC_CLK_NS
) (
   input  wire         clk,
   input  wire         rst,
   input  wire         sclk,
   input  wire         mosi,
   input  wire         ncs_n,
   input  wire         motion_evt,
   output wire         miso,
   output wire         miso_oe,
   output reg          frame_strobe_ff,
   output reg          laser_drive_off_pin_n_ff,
   output reg  [7:0]   laser_current_code_ff,
   output reg  [1:0]   laser_span_ff,
   output reg  [1:0]   power_state_ff,
   output reg          laser_setting_ok_ff
);
   // power states, codes equal the reported mode
   localparam [1:0] ST_ACT = 2'h0;
   localparam [1:0] ST_R1  = 2'h1;
   localparam [1:0] ST_R2  = 2'h2;
   localparam [1:0] ST_R3  = 2'h3;

   // register storage
   reg  [7:0] config_ff;         // awake bit and active rate
   reg  [7:0] run_idle_ff;       // run_idle_timeout
   reg  [7:0] r1_per_ff;         // first_rest_period_code
   reg  [7:0] r1_idle_ff;        // first_rest_idle_count
   reg  [7:0] r2_per_ff;         // second_rest_period_code
   reg  [7:0] r2_idle_ff;        // second_rest_idle_count
   reg  [7:0] r3_per_ff;         // third_rest_period_code
   reg  [7:0] lctrl_ff;          // laser_drive_control
   reg  [7:0] lcur_ff;           // laser_current_setting
   reg  [7:0] lcur_inv_ff;       // complement copy of current
   reg  [7:0] lctrl_inv_ff;      // complement copy of span
   reg        mot_seen_ff;       // motion since last motion read

   // sequencer state
   reg  [1:0]  state_ff;         // present power state
   reg  [1:0]  nxt_state;
   reg  [8:0]  per_cnt_ff;       // base ticks in this frame
   reg  [8:0]  nxt_per_cnt;
   reg  [14:0] idle_cnt_ff;      // quiet frames in this state
   reg  [14:0] nxt_idle_cnt;
   reg         nxt_frame;
   reg  [8:0]  per_tgt;          // base ticks per frame
   reg  [14:0] idle_tgt;         // quiet frames before stepping down
   reg  [7:0]  rdata;            // read mux

   // serial port and internal wires
   wire [6:0] addr;
   wire [7:0] wdata;
   wire       wr;
   wire       rd;
   wire       act_tick;
   wire       hib_tick;
   wire       base_tick;
   wire       state_chg;
   wire       stay_active;
   wire       mot_read;
   wire [1:0] span;
   wire       span_pair_ok;
   wire       cur_pair_ok;
   wire       set_ok;
   wire       cw_mode;
   wire       kill;

   pmlc_serial u_serial (
      .clk        (clk),
      .rst        (rst),
      .sclk       (sclk),
      .mosi       (mosi),
      .ncs_n      (ncs_n),
      .rdata      (rdata),
      .addr_ff    (addr),
      .wdata_ff   (wdata),
      .wr_ff      (wr),
      .rd_ff      (rd),
      .miso_ff    (miso),
      .miso_oe_ff (miso_oe)
   );

   // active base, one tick per millisecond of system time
   pmlc_tick #(.DIV(ACT_BASE_CYC)) u_act_tick ( // R2
      .clk     (clk),
      .rst     (rst),
      .restart (state_chg),
      .tick_ff (act_tick)
   );

   // hibernate base, one tick per 10ms
   pmlc_tick #(.DIV(HIB_BASE_CYC)) u_hib_tick ( // R2
      .clk     (clk),
      .rst     (rst),
      .restart (state_chg),
      .tick_ff (hib_tick)
   );

   assign state_chg   = (nxt_state != state_ff);
   assign base_tick   = (state_ff == ST_ACT) ? act_tick : hib_tick; // R2
   assign stay_active = config_ff[`PMLC_B_AWAKE];
   assign mot_read    = rd && (addr == `PMLC_A_MOTION || addr == `PMLC_A_MOTION_ALT);

   // laser pair checks look only at present contents
   assign span         = {lctrl_ff[`PMLC_B_SPAN_HI], lctrl_ff[`PMLC_B_SPAN_LO]}; // R10
   assign span_pair_ok = (lctrl_ff[`PMLC_B_SPAN_HI] != lctrl_inv_ff[`PMLC_B_SPAN_HI]) &&
                         (lctrl_ff[`PMLC_B_SPAN_LO] != lctrl_inv_ff[`PMLC_B_SPAN_LO]); // R8 R9
   assign cur_pair_ok  = ((lcur_ff ^ lcur_inv_ff) == 8'hff); // R14 R9
   assign set_ok       = span_pair_ok && cur_pair_ok && (span != `PMLC_SPAN_BAD); // R10
   assign cw_mode      = (lctrl_ff[`PMLC_F_CAL] == `PMLC_CAL_CW); // R11
   assign kill         = lctrl_ff[`PMLC_B_KILL];

   // frame period and idle limit for the present state
   always @* begin
      per_tgt  = {1'b0, r3_per_ff} + 9'h001; // R7
      idle_tgt = 15'h0000;
      case (state_ff)
         ST_ACT: begin
            per_tgt  = {5'h00, {1'b0, config_ff[`PMLC_F_RATE]} + `PMLC_RUN_RATE_OFS};
            idle_tgt = {4'h0, run_idle_ff, 3'h0}; // R1
         end
         ST_R1: begin
            per_tgt  = {1'b0, r1_per_ff} + 9'h001; // R3
            idle_tgt = {3'h0, r1_idle_ff, 4'h0}; // R4
         end
         ST_R2: begin
            per_tgt  = {1'b0, r2_per_ff} + 9'h001; // R5
            idle_tgt = {r2_idle_ff, 7'h00}; // R6
         end
         default: begin
            per_tgt  = {1'b0, r3_per_ff} + 9'h001; // R7
            idle_tgt = 15'h0000;
         end
      endcase
   end

   // next-state logic for frames, idle count and stepping down
   always @* begin
      nxt_state    = state_ff;
      nxt_per_cnt  = per_cnt_ff;
      nxt_idle_cnt = idle_cnt_ff;
      nxt_frame    = 1'b0;
      if (base_tick) begin
         if (per_cnt_ff + 9'h001 >= per_tgt) begin
            nxt_per_cnt  = 9'h000;
            nxt_frame    = 1'b1;
            nxt_idle_cnt = idle_cnt_ff + 15'h0001;
         end else begin
            nxt_per_cnt = per_cnt_ff + 9'h001;
         end
      end
      if (nxt_frame && state_ff != ST_R3 && !stay_active &&
          nxt_idle_cnt >= idle_tgt) begin
         // step down one rest level
         case (state_ff)
            ST_ACT:  nxt_state = ST_R1; // R1
            ST_R1:   nxt_state = ST_R2; // R4
            ST_R2:   nxt_state = ST_R3; // R6
            default: nxt_state = ST_R3; // R19
         endcase
      end
      if (motion_evt) begin
         nxt_idle_cnt = 15'h0000; // R18
         nxt_state    = ST_ACT; // R18
      end
      if (stay_active) begin
         nxt_state = ST_ACT; // R16
      end
      if (nxt_state != state_ff) begin
         // a new state starts with fresh counters
         nxt_per_cnt  = 9'h000;
         nxt_idle_cnt = 15'h0000;
      end
   end

   // sequencer registers
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff        <= ST_ACT;
         per_cnt_ff      <= 9'h000;
         idle_cnt_ff     <= 15'h0000;
         frame_strobe_ff <= 1'b0;
         power_state_ff  <= ST_ACT;
      end else begin
         state_ff        <= nxt_state;
         per_cnt_ff      <= nxt_per_cnt;
         idle_cnt_ff     <= nxt_idle_cnt;
         frame_strobe_ff <= nxt_frame;
         power_state_ff  <= nxt_state; // R17
      end
   end

   // register writes; a motion read drops calibration back to off
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         config_ff    <= `PMLC_RV_CONFIG;
         run_idle_ff  <= `PMLC_RV_RUN_IDLE;
         r1_per_ff    <= `PMLC_RV_R1_PER;
         r1_idle_ff   <= `PMLC_RV_R1_IDLE;
         r2_per_ff    <= `PMLC_RV_R2_PER;
         r2_idle_ff   <= `PMLC_RV_R2_IDLE;
         r3_per_ff    <= `PMLC_RV_R3_PER;
         lctrl_ff     <= `PMLC_RV_ZERO;
         lcur_ff      <= `PMLC_RV_ZERO;
         lcur_inv_ff  <= `PMLC_RV_ZERO;
         lctrl_inv_ff <= `PMLC_RV_ZERO;
      end else begin
         if (wr) begin
            case (addr)
               `PMLC_A_CONFIG:    config_ff    <= wdata;
               `PMLC_A_RUN_IDLE:  run_idle_ff  <= wdata;
               `PMLC_A_R1_PER:    r1_per_ff    <= wdata;
               `PMLC_A_R1_IDLE:   r1_idle_ff   <= wdata;
               `PMLC_A_R2_PER:    r2_per_ff    <= wdata;
               `PMLC_A_R2_IDLE:   r2_idle_ff   <= wdata;
               `PMLC_A_R3_PER:    r3_per_ff    <= wdata;
               `PMLC_A_LCTRL:     lctrl_ff     <= wdata; // R11
               `PMLC_A_LCUR:      lcur_ff      <= wdata;
               `PMLC_A_LCUR_INV:  lcur_inv_ff  <= wdata;
               `PMLC_A_LCTRL_INV: lctrl_inv_ff <= wdata;
               default: ;
            endcase
         end
         if (mot_read) begin
            lctrl_ff[`PMLC_F_CAL] <= `PMLC_CAL_OFF; // R12
         end
      end
   end

   // sticky motion flag; new motion wins over the clearing read
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         mot_seen_ff <= 1'b0;
      end else if (motion_evt) begin
         mot_seen_ff <= 1'b1;
      end else if (mot_read) begin
         mot_seen_ff <= 1'b0;
      end
   end

   // read mux; unmapped addresses read zero
   always @* begin
      rdata = 8'h00;
      case (addr)
         `PMLC_A_MOTION, `PMLC_A_MOTION_ALT: begin
            rdata[`PMLC_B_MOT]  = mot_seen_ff;
            rdata[`PMLC_B_LSOK] = set_ok;
         end
         `PMLC_A_CONFIG:    rdata = config_ff;
         `PMLC_A_RUN_IDLE:  rdata = run_idle_ff;
         `PMLC_A_R1_PER:    rdata = r1_per_ff;
         `PMLC_A_R1_IDLE:   rdata = r1_idle_ff;
         `PMLC_A_R2_PER:    rdata = r2_per_ff;
         `PMLC_A_R2_IDLE:   rdata = r2_idle_ff;
         `PMLC_A_R3_PER:    rdata = r3_per_ff;
         `PMLC_A_LCTRL:     rdata = lctrl_ff;
         `PMLC_A_LCUR:      rdata = lcur_ff;
         `PMLC_A_LCUR_INV:  rdata = lcur_inv_ff;
         `PMLC_A_LCTRL_INV: rdata = lctrl_inv_ff;
         `PMLC_A_OBS:       rdata = {state_ff, 6'h00}; // R17
         default:           rdata = 8'h00;
      endcase
   end

   // laser outputs; the pin stays high unless settings are sound
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         laser_drive_off_pin_n_ff <= 1'b1;
         laser_current_code_ff    <= 8'h00;
         laser_span_ff            <= 2'h0;
         laser_setting_ok_ff      <= 1'b0;
      end else begin
         laser_current_code_ff <= lcur_ff; // R15
         laser_span_ff         <= span; // R10
         laser_setting_ok_ff   <= set_ok; // R8 R14
         if (kill || !set_ok) begin
            laser_drive_off_pin_n_ff <= 1'b1; // R13 R8 R14
         end else begin
            // on for a frame capture, or steadily in calibration
            laser_drive_off_pin_n_ff <= ~(nxt_frame | cw_mode); // R11
         end
      end
   end
endmodule
`default_nettype wire

// ==== sim/pmlc_host.sv ====
// controller model driving the four-wire register port
`timescale 1ns/1ps
`default_nettype none
module pmlc_host (
   input  wire logic       clk,
   input  wire logic       miso,
   output var  logic       sclk,
   output var  logic       mosi,
   output var  logic       ncs_n,
   output var  logic [7:0] rd_val,
   output var  logic       rd_done
);
   // idle: deselected, clock parked high (mode 3)
   initial begin
      sclk = 1'b1;
      mosi = 1'b0;
      ncs_n = 1'b1;
      rd_val = 8'h00;
      rd_done = 1'b0;
   end
   // one frame: command byte then data byte, msb first, four clocks a half
   task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d);
      logic [15:0] sh;
      sh = {wr, a, d};
      @(posedge clk) ncs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
         mosi <= sh[i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         // read data taken on the rising edge
         if (i < 8) rd_val[i] <= miso;
      end
      // select held until the write has landed
      repeat (8) @(posedge clk);
      ncs_n <= 1'b1;
      mosi <= ~mosi; // released line never shows the stale bit
      rd_done <= ~wr;
      @(posedge clk) rd_done <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== sim/pmlc_top_asserts.sv ====
// checker for the power state and laser outputs of the block
`timescale 1ns/1ps
`default_nettype none
module pmlc_top_asserts #(
   parameter integer ACT_BASE_CYC = 200000,
   parameter integer HIB_BASE_CYC = 2000000
) (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       ncs_n,
   input wire logic       motion_evt,
   input wire logic       frame_strobe_ff,
   input wire logic       laser_drive_off_pin_n_ff,
   input wire logic [7:0] laser_current_code_ff,
   input wire logic [1:0] laser_span_ff,
   input wire logic [1:0] power_state_ff,
   input wire logic       laser_setting_ok_ff
);
   // shortest legal frame gap, two base periods
   localparam integer MINGAP = 2 * (ACT_BASE_CYC < HIB_BASE_CYC ? ACT_BASE_CYC : HIB_BASE_CYC);
   logic [31:0] gap_ff;  // cycles since last strobe, saturating
   logic [31:0] nxt_gap; // next gap count
   assign nxt_gap = frame_strobe_ff ? 32'h1 : (&gap_ff ? gap_ff : gap_ff + 32'h1);
   // starts saturated so the first strobe never trips
   always_ff @(posedge clk or posedge rst) begin
      if (rst) gap_ff <= 32'hffffffff;
      else gap_ff <= nxt_gap;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_mot_active; motion_evt |=> power_state_ff == 2'h0; endproperty
   a_mot_active: assert property (p_mot_active) else $error("no return on motion");
   property p_on_frame; ($changed(power_state_ff) && power_state_ff != 2'h0) |-> frame_strobe_ff; endproperty
   a_on_frame: assert property (p_on_frame) else $error("step off a frame");
   property p_order; ($changed(power_state_ff) && power_state_ff != 2'h0) |-> power_state_ff == $past(power_state_ff) + 2'h1; endproperty
   a_order: assert property (p_order) else $error("step skipped a state");
   property p_hold3; (power_state_ff == 2'h3 && !motion_evt) |=> power_state_ff inside {2'h0, 2'h3}; endproperty
   a_hold3: assert property (p_hold3) else $error("left deepest rest");
   property p_span_bad; laser_span_ff == 2'h2 |-> !laser_setting_ok_ff; endproperty
   a_span_bad: assert property (p_span_bad) else $error("bad span flagged ok");
   property p_bad_off; (!laser_setting_ok_ff) [*2] |-> laser_drive_off_pin_n_ff; endproperty
   a_bad_off: assert property (p_bad_off) else $error("laser on with bad setting");
   property p_gap; frame_strobe_ff |-> gap_ff >= MINGAP; endproperty
   a_gap: assert property (p_gap) else $error("frames too close");
   property p_code; $changed(laser_current_code_ff) |-> !ncs_n; endproperty
   a_code: assert property (p_code) else $error("code moved without a write");
   c_rest3: cover property (power_state_ff == 2'h3);
   c_ok: cover property ($rose(laser_setting_ok_ff));
   c_back: cover property (power_state_ff == 2'h3 ##1 power_state_ff == 2'h0);
endmodule
`default_nettype wire

// ==== sim/power_mode_laser_control_tb.sv ====
// self-checking bench for the power mode and laser control block
`timescale 1ns/1ps
`default_nettype none
module power_mode_laser_control_tb;
   localparam int ACT = 4;  // shortened active base
   localparam int HIB = 8;  // shortened rest base
   localparam int LIMIT = 30000;
   localparam logic [6:0] RA [9] = '{7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h18, 7'h1a, 7'h1c, 7'h11};
   localparam logic [7:0] RV [9] = '{8'h04, 8'h01, 8'h1f, 8'h09, 8'h2f, 8'h31, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] SC [4] = '{8'h00, 8'h20, 8'ha0, 8'h80};
   localparam logic [6:0] MA [2] = '{7'h02, 7'h42};
   logic        clk = 1'b0, rst = 1'b1, motion_evt = 1'b1, snap = 1'b0, pmot = 1'b0;
   logic [1:0]  pst = 2'h0;
   wire logic   sclk, mosi, ncs_n, miso, miso_oe, strobe, pin_n, ok, rdd;
   wire logic [7:0] code, rdv;
   wire logic [1:0] span, st;
   int          n_mismatch = 0, tests_run = 0, cyc = 0, last_s = -1, nfr = 0;
   logic [15:0] q_rd [$];  // {mask, value}
   logic [9:0]  q_st [$];  // {state, frames}, ff frames = any
   int          q_per [$]; // expected frame gap
   logic [10:0] q_out [$]; // {code, span, ok}
   pmlc_top #(.ACT_BASE_CYC(ACT), .HIB_BASE_CYC(HIB)) u_dut (
      .clk(clk), .rst(rst), .sclk(sclk), .mosi(mosi), .ncs_n(ncs_n), .motion_evt(motion_evt),
      .miso(miso), .miso_oe(miso_oe), .frame_strobe_ff(strobe), .laser_drive_off_pin_n_ff(pin_n),
      .laser_current_code_ff(code), .laser_span_ff(span), .power_state_ff(st),
      .laser_setting_ok_ff(ok));
   pmlc_host u_host (.clk(clk), .miso(miso), .sclk(sclk), .mosi(mosi), .ncs_n(ncs_n),
      .rd_val(rdv), .rd_done(rdd));
   initial begin
      forever #2.5 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_mismatch++;
         results();
      end
   end
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // watcher: each result seen takes the oldest note
   always @(posedge clk) begin
      logic [15:0] e;
      #1;
      if (pmot) nfr = 0;
      pmot = motion_evt;
      if (strobe) begin
         if (last_s >= 0 && q_per.size() > 0) cmp(16'(cyc - last_s), 16'(q_per.pop_front()));
         last_s = cyc;
         nfr++;
      end
      if (st !== pst) begin
         if (q_st.size() == 0) cmp(16'hbad0, {14'h0, st});
         else begin
            e = 16'(q_st.pop_front());
            cmp({14'h0, st}, {14'h0, e[9:8]});
            if (e[7:0] != 8'hff) cmp(16'(nfr), {8'h0, e[7:0]});
         end
         nfr = 0;
         pst = st;
      end
      if (rdd) begin
         e = q_rd.size() > 0 ? q_rd.pop_front() : 16'h00ff;
         // miso_oe must still stand while select is only now released
         cmp({7'h0, miso_oe, rdv & e[15:8]}, {8'h1, e[7:0]});
      end
      if (snap) begin
         e = q_out.size() > 0 ? 16'(q_out.pop_front()) : 16'hffff;
         cmp({5'h0, code, span, ok}, e);
         snap = 1'b0;
      end
   end
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      u_host.xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] m, input logic [7:0] v);
      q_rd.push_back({m, v});
      u_host.xfer(1'b0, a, 8'h00);
   endtask
   // let register and output stages settle, then note the laser outputs
   task automatic out(input logic [7:0] c, input logic [1:0] s, input logic k);
      repeat (3) @(posedge clk);
      q_out.push_back({c, s, k});
      snap = 1'b1;
   endtask
   task automatic wait_strb();
      int i;
      i = 0;
      do begin
         @(posedge clk);
         #1;
         i++;
      end while (!strobe && i < 2000);
   endtask
   // note the next frame gap once a frame has passed
   task automatic per(input int p);
      wait_strb();
      @(posedge clk);
      q_per.push_back(p);
      wait_strb();
   endtask
   task automatic pin_low(input int n, output int lo);
      lo = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         lo += (pin_n === 1'b0);
      end
   endtask
   task automatic wait_st(input logic [1:0] s);
      for (int i = 0; i < 4000 && st !== s; i++) begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic results();
      n_mismatch += q_rd.size() + q_st.size() + q_per.size() + q_out.size();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // main sequence; motion held high keeps the block active early on
   initial begin
      logic [7:0] c, r3;
      int lo;
      void'($urandom(58));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      foreach (RA[i]) rd(RA[i], 8'hff, RV[i]);
      out(8'h00, 2'h0, 1'b0);
      c = 8'h01 + 8'($urandom_range(253));
      wr(7'h1d, ~c);
      out(8'h00, 2'h0, 1'b0);
      wr(7'h1c, c);
      // span pair still both zero, so not yet complementary
      out(c, 2'h0, 1'b0);
      // every span code, partner register written first
      foreach (SC[i]) begin
         wr(7'h1f, ~SC[i] & 8'ha0);
         wr(7'h1a, SC[i]);
         out(c, {SC[i][7], SC[i][5]}, i != 3);
      end
      wr(7'h1a, 8'ha0);
      out(c, 2'h3, 1'b0);
      wr(7'h1f, 8'h00);
      out(c, 2'h3, 1'b1);
      wr(7'h1d, c);
      out(c, 2'h3, 1'b0);
      wr(7'h1d, ~c);
      rd(7'h02, 8'ha0, 8'ha0);
      wr(7'h1a, 8'ha1);
      pin_low(80, lo);
      cmp(16'(lo), 16'h0);
      // continuous-on, ended by a motion read at either address
      foreach (MA[i]) begin
         wr(7'h1a, 8'haa);
         pin_low(80, lo);
         cmp(16'(lo), 16'd80);
         rd(MA[i], 8'h20, 8'h20);
         pin_low(80, lo);
         cmp(16'(lo inside {[1:3]}), 16'h1);
         rd(7'h1a, 8'hff, 8'ha0);
      end
      // short idle counts, then release motion and let it step down
      wr(7'h13, 8'h02);
      wr(7'h15, 8'h01);
      wr(7'h16, 8'h02);
      wr(7'h17, 8'h01);
      r3 = 8'($urandom_range(3, 1));
      wr(7'h18, r3);
      per(8 * ACT);
      @(posedge clk) motion_evt <= 1'b0;
      q_st.push_back({2'h1, 8'd16});
      q_st.push_back({2'h2, 8'd16});
      q_st.push_back({2'h3, 8'd128});
      wait_st(2'h1);
      per(2 * HIB);
      wait_st(2'h2);
      per(3 * HIB);
      wait_st(2'h3);
      repeat (3) per((int'(r3) + 1) * HIB);
      q_st.push_back({2'h0, 8'hff});
      @(posedge clk) motion_evt <= 1'b1;
      @(posedge clk) motion_evt <= 1'b0;
      wr(7'h12, 8'h2e);
      repeat (700) @(posedge clk);
      rd(7'h2e, 8'hc0, 8'h00);
      results();
   end
endmodule
bind pmlc_top pmlc_top_asserts #(.ACT_BASE_CYC(ACT_BASE_CYC), .HIB_BASE_CYC(HIB_BASE_CYC)) u_chk (
   .clk(clk), .rst(rst), .ncs_n(ncs_n), .motion_evt(motion_evt),
   .frame_strobe_ff(frame_strobe_ff), .laser_drive_off_pin_n_ff(laser_drive_off_pin_n_ff),
   .laser_current_code_ff(laser_current_code_ff), .laser_span_ff(laser_span_ff),
   .power_state_ff(power_state_ff), .laser_setting_ok_ff(laser_setting_ok_ff));
`default_nettype wire
